// ### sfcp_pkg.sv
// shared constants, register map and gamma table for the switch fade control block
package sfcp_pkg;
	// clock and timing, each time in its own unit with the derived cycle count
	localparam int CLK_HZ           = 40_000_000;
	localparam int DEBOUNCE_MS      = 37;
	localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int FADE_COUNT_MS    = 7;
	localparam int GAMMA_STEPS      = 63;
	localparam int STEP_UNIT_CYC    = (FADE_COUNT_MS * (CLK_HZ / 1000)) / GAMMA_STEPS;
	localparam int INSTANT_US       = 75;
	localparam int INSTANT_CYC      = INSTANT_US * (CLK_HZ / 1_000_000);

	// widths and the top ramp step
	localparam int DEB_W            = 21;
	localparam int TMR_W            = 24;
	localparam int STEP_W           = 6;
	localparam int LVL_W            = 10;
	localparam logic [STEP_W-1:0] STEP_TOP = 6'h3e;

	// register offsets
	localparam logic [7:0] ADDR_MODE_CFG   = 8'h01;
	localparam logic [7:0] ADDR_LOW_SCALE  = 8'h02;
	localparam logic [7:0] ADDR_FADE_ON    = 8'h03;
	localparam logic [7:0] ADDR_FADE_OFF   = 8'h04;
	localparam logic [7:0] ADDR_CUR_A      = 8'h05;
	localparam logic [7:0] ADDR_CUR_B      = 8'h06;
	localparam logic [7:0] ADDR_FAULT_STAT = 8'h07;
	localparam logic [7:0] ADDR_OPEN_CFG   = 8'h08;
	localparam logic [7:0] ADDR_WRITE_GATE = 8'h09;
	localparam logic [7:0] ADDR_PROT_CFG   = 8'h0a;

	// reset values and unlock key
	localparam logic [7:0] RST_MODE_CFG   = 8'h01;
	localparam logic [7:0] RST_LOW_SCALE  = 8'h00;
	localparam logic [7:0] RST_FADE       = 8'h64;
	localparam logic [7:0] RST_CUR        = 8'h00;
	localparam logic [7:0] RST_OPEN_CFG   = 8'h1a;
	localparam logic [7:0] RST_WRITE_GATE = 8'h00;
	localparam logic [7:0] RST_PROT_CFG   = 8'h78;
	localparam logic [7:0] UNLOCK_KEY     = 8'hc5;

	// mode and low-scale register fields
	localparam int MODE_PULSE_BIT   = 0;
	localparam int MODE_FADE_ON_REG = 1;
	localparam int MODE_FADE_OFF_REG = 2;
	localparam int LOW_SCALE_LSB    = 0;

	// protection register fields
	localparam int PROT_THERMAL_RPT = 6;
	localparam int PROT_SHORT_RPT   = 5;
	localparam int PROT_SHORT_DET   = 4;
	localparam int PROT_OPEN_RPT    = 3;
	localparam int PROT_OPEN_DET_LSB = 0;

	// fault status register fields
	localparam int STAT_THERMAL     = 6;
	localparam int STAT_OPEN_LSB    = 3;
	localparam int STAT_SHORT_LSB   = 0;

	// relative brightness per ramp step, 0 to full scale 1000
	localparam logic [LVL_W-1:0] GAMMA [0:GAMMA_STEPS-1] = '{
		10'd0, 10'd2, 10'd4, 10'd6, 10'd8, 10'd10, 10'd12, 10'd16,
		10'd20, 10'd24, 10'd28, 10'd32, 10'd36, 10'd42, 10'd48, 10'd54,
		10'd60, 10'd66, 10'd72, 10'd80, 10'd88, 10'd96, 10'd104, 10'd112,
		10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
		10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
		10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
		10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
		10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000
	};
endpackage

// ### sfcp_channel.sv
// one high-current channel: switch debounce, on/off latch and gamma ramp stepping
`timescale 1ns/100ps
`default_nettype none
module sfcp_channel
	import sfcp_pkg::*;
#(
	parameter int DEB_CYCLES  = DEBOUNCE_CYC,
	parameter int STEP_CYCLES = STEP_UNIT_CYC
)(
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              sw_in,
	input  wire logic              pulse_mode_in,
	input  wire logic [7:0]        fade_on_in,
	input  wire logic [7:0]        fade_off_in,
	output logic                   on_out,
	output logic [STEP_W-1:0]      step_out
);
	typedef struct packed {
		logic              primed;
		logic              acc;
		logic [DEB_W-1:0]  deb;
		logic              on;
		logic [STEP_W-1:0] step;
		logic [TMR_W-1:0]  tmr;
	} sfcp_ch_s;

	sfcp_ch_s q_r;
	sfcp_ch_s q_nxt;

	// next-state logic: debounce, latch, ramp
	always_comb
	begin
		logic [7:0]        cnt;
		logic [TMR_W-1:0]  period;
		logic [STEP_W-1:0] goal;
		logic              fall;
		logic              rise;
		cnt    = 8'h00;
		period = '0;
		goal   = '0;
		fall   = 1'b0;
		rise   = 1'b0;
		q_nxt  = q_r;
		// both edges filtered; first stable level after reset only primes
		if ((sw_in != q_r.acc) || !q_r.primed)
		begin
			if (q_r.deb == DEB_W'(DEB_CYCLES - 1))
			begin
				q_nxt.deb    = '0;
				q_nxt.acc    = sw_in;
				q_nxt.primed = 1'b1;
				fall = q_r.primed && q_r.acc && !sw_in;
				rise = q_r.primed && !q_r.acc && sw_in;
			end
			else
			begin
				q_nxt.deb = q_r.deb + 1'b1;
			end
		end
		else
		begin
			q_nxt.deb = '0;
		end
		// pulse mode toggles on low, level mode follows the level
		if (pulse_mode_in)
		begin
			if (fall)
				q_nxt.on = !q_r.on;
		end
		else
		begin
			if (rise)
				q_nxt.on = 1'b1;
			else if (fall)
				q_nxt.on = 1'b0;
		end
		// a reversal restarts the step timer but keeps the reached step
		if (q_nxt.on != q_r.on)
			q_nxt.tmr = '0;
		else
		begin
			goal   = q_r.on ? STEP_TOP : '0;
			cnt    = q_r.on ? fade_on_in : fade_off_in;
			period = TMR_W'(cnt) * TMR_W'(STEP_CYCLES);
			if (q_r.step == goal)
				q_nxt.tmr = '0;
			else if (cnt == 8'h00)
			begin
				// cancelled fade: jump after the short instant delay
				if (q_r.tmr == TMR_W'(INSTANT_CYC - 1))
				begin
					q_nxt.step = goal;
					q_nxt.tmr  = '0;
				end
				else
					q_nxt.tmr = q_r.tmr + 1'b1;
			end
			else if (q_r.tmr == period - 1'b1)
			begin
				q_nxt.tmr  = '0;
				q_nxt.step = q_r.on ? q_r.step + 1'b1 : q_r.step - 1'b1;
			end
			else
				q_nxt.tmr = q_r.tmr + 1'b1;
		end
	end

	// state register; channel powers up off at step zero
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

	assign on_out   = q_r.on;
	assign step_out = q_r.step;
endmodule
`default_nettype wire

// ### sfcp_top.sv
// switch fade control and protection: register map, write gate, fault pin, two channels
// Function
// - writes other than to the gate ignored unless gate holds unlock key
// - thermal report bit gates fault pin
// - short report bit gates fault pin
// - short detect bit enables short detection
// - open report bit gates fault pin
// - per-output bits enable open detection
// - each switch input drives own channel
// - mode bit picks pulse or level
// - both channels start off after reset
// - pulse mode: debounced low toggles channel
// - level mode: debounced high turns on
// - level mode: low ramps channel down
// - on ramp timed by fade-on setting
// - ramps walk 63 gamma steps
// - new toggle reverses ramp mid-cycle
// - debounce both edges of switch input
// - high-channel current in 256 steps
// - low channel current in 8 steps
// - fade register counts 7 ms each
// - fade value zero switches almost instantly
// - steps follow fixed gamma table
`timescale 1ns/100ps
`default_nettype none
module sfcp_top
	import sfcp_pkg::*;
#(
	parameter int DEB_CYCLES  = sfcp_pkg::DEBOUNCE_CYC,
	parameter int STEP_CYCLES = sfcp_pkg::STEP_UNIT_CYC,
	parameter int N_HIGH      = 2,
	parameter int N_OUT       = 3
)(
	input  wire logic                        CLK_IN,
	input  wire logic                        RST_N_IN,
	input  wire logic [7:0]                  REG_ADDR_IN,
	input  wire logic                        REG_WR_IN,
	input  wire logic [7:0]                  REG_WDATA_IN,
	output logic [7:0]                       REG_RDATA_OUT,
	input  wire logic [N_HIGH-1:0]           HIGH_CHANNEL_SWITCH_INPUTS_IN,
	input  wire logic [7:0]                  FADE_ON_TIME_PIN_IN,
	input  wire logic [7:0]                  FADE_OFF_TIME_PIN_IN,
	input  wire logic                        THERMAL_SHUTDOWN_IN,
	input  wire logic [N_OUT-1:0]            SHORT_SENSE_IN,
	input  wire logic [N_OUT-1:0]            OPEN_SENSE_IN,
	output logic                             FAULT_FLAG_N_OUT,
	output logic                             FAULT_FLAG_N_OE_OUT,
	output logic [N_HIGH-1:0]                CHANNEL_ON_OUT,
	output logic [sfcp_pkg::LVL_W-1:0]       HIGH_CURRENT_OUTPUT_A_LEVEL_OUT,
	output logic [sfcp_pkg::LVL_W-1:0]       HIGH_CURRENT_OUTPUT_B_LEVEL_OUT,
	output logic [7:0]                       HIGH_CURRENT_OUTPUT_A_SCALE_OUT,
	output logic [7:0]                       HIGH_CURRENT_OUTPUT_B_SCALE_OUT,
	output logic [2:0]                       LOW_CHANNEL_CURRENT_SCALE_OUT,
	output logic [N_OUT-1:0]                 SHORT_DETECT_ACTIVE_OUT,
	output logic [N_OUT-1:0]                 OPEN_DETECT_ACTIVE_OUT
);
	typedef struct packed {
		logic [7:0]        write_gate_key;
		logic [7:0]        mode_cfg;
		logic [7:0]        low_scale;
		logic [7:0]        fade_on;
		logic [7:0]        fade_off;
		logic [7:0]        cur_a;
		logic [7:0]        cur_b;
		logic [7:0]        open_cfg;
		logic [7:0]        fault_protection_config;
		logic [7:0]        rdata;
		logic              fault;
		logic [LVL_W-1:0]  level_a;
		logic [LVL_W-1:0]  level_b;
		logic [N_HIGH-1:0] sw_s1;
		logic [N_HIGH-1:0] sw_s2;
		logic [7:0]        pin_on_s1;
		logic [7:0]        pin_on_s2;
		logic [7:0]        pin_off_s1;
		logic [7:0]        pin_off_s2;
		logic              tsd_s1;
		logic              tsd_s2;
		logic [N_OUT-1:0]  short_s1;
		logic [N_OUT-1:0]  short_s2;
		logic [N_OUT-1:0]  open_s1;
		logic [N_OUT-1:0]  open_s2;
	} sfcp_top_s;

	sfcp_top_s q_r;
	sfcp_top_s q_nxt;

	logic [N_HIGH-1:0] ch_on;
	logic [STEP_W-1:0] ch_step [N_HIGH];
	logic [7:0]        fade_on_sel;
	logic [7:0]        fade_off_sel;
	logic [N_OUT-1:0]  short_seen;
	logic [N_OUT-1:0]  open_seen;
	logic              wr_ok;

	// fade time from register or from the digitised pin setting
	assign fade_on_sel  = q_r.mode_cfg[MODE_FADE_ON_REG] ? q_r.fade_on : q_r.pin_on_s2;
	assign fade_off_sel = q_r.mode_cfg[MODE_FADE_OFF_REG] ? q_r.fade_off : q_r.pin_off_s2;

	// detection enables mask the raw sense lines
	assign short_seen = q_r.fault_protection_config[PROT_SHORT_DET]
		? q_r.short_s2 : '0;
	assign open_seen  = q_r.open_s2
		& q_r.fault_protection_config[PROT_OPEN_DET_LSB +: N_OUT];

	// the gate register itself is always writable, so a locked map can be opened
	assign wr_ok = REG_WR_IN && ((REG_ADDR_IN == ADDR_WRITE_GATE)
		|| (q_r.write_gate_key == UNLOCK_KEY));

	// one independent controller per switch input
	genvar gi;
	generate
		for (gi = 0; gi < N_HIGH; gi++)
		begin : g_ch
			sfcp_channel #(
				.DEB_CYCLES  (DEB_CYCLES),
				.STEP_CYCLES (STEP_CYCLES)
			) u_ch (
				.clk_in        (CLK_IN),
				.rst_n_in      (RST_N_IN),
				.sw_in         (q_r.sw_s2[gi]),
				.pulse_mode_in (q_r.mode_cfg[MODE_PULSE_BIT]),
				.fade_on_in    (fade_on_sel),
				.fade_off_in   (fade_off_sel),
				.on_out        (ch_on[gi]),
				.step_out      (ch_step[gi])
			);
		end
	endgenerate

	// next-state logic: synchronisers, register writes, read mux, fault, levels
	always_comb
	begin
		q_nxt = q_r;
		// two-stage synchronisers for everything arriving from pins
		q_nxt.sw_s1      = HIGH_CHANNEL_SWITCH_INPUTS_IN;
		q_nxt.sw_s2      = q_r.sw_s1;
		q_nxt.pin_on_s1  = FADE_ON_TIME_PIN_IN;
		q_nxt.pin_on_s2  = q_r.pin_on_s1;
		q_nxt.pin_off_s1 = FADE_OFF_TIME_PIN_IN;
		q_nxt.pin_off_s2 = q_r.pin_off_s1;
		q_nxt.tsd_s1     = THERMAL_SHUTDOWN_IN;
		q_nxt.tsd_s2     = q_r.tsd_s1;
		q_nxt.short_s1   = SHORT_SENSE_IN;
		q_nxt.short_s2   = q_r.short_s1;
		q_nxt.open_s1    = OPEN_SENSE_IN;
		q_nxt.open_s2    = q_r.open_s1;

		// register writes, dropped while the gate is locked
		if (wr_ok)
		begin
			case (REG_ADDR_IN)
				ADDR_WRITE_GATE: q_nxt.write_gate_key = REG_WDATA_IN;
				ADDR_MODE_CFG:   q_nxt.mode_cfg       = REG_WDATA_IN;
				ADDR_LOW_SCALE:  q_nxt.low_scale      = REG_WDATA_IN;
				ADDR_FADE_ON:    q_nxt.fade_on        = REG_WDATA_IN;
				ADDR_FADE_OFF:   q_nxt.fade_off       = REG_WDATA_IN;
				ADDR_CUR_A:      q_nxt.cur_a          = REG_WDATA_IN;
				ADDR_CUR_B:      q_nxt.cur_b          = REG_WDATA_IN;
				ADDR_OPEN_CFG:   q_nxt.open_cfg       = REG_WDATA_IN;
				ADDR_PROT_CFG:   q_nxt.fault_protection_config = REG_WDATA_IN & 8'h7f;
				default:         q_nxt.write_gate_key = q_r.write_gate_key;
			endcase
		end

		// registered read data follows the address; unmapped reads zero
		case (REG_ADDR_IN)
			ADDR_WRITE_GATE: q_nxt.rdata = q_r.write_gate_key;
			ADDR_MODE_CFG:   q_nxt.rdata = q_r.mode_cfg;
			ADDR_LOW_SCALE:  q_nxt.rdata = q_r.low_scale;
			ADDR_FADE_ON:    q_nxt.rdata = q_r.fade_on;
			ADDR_FADE_OFF:   q_nxt.rdata = q_r.fade_off;
			ADDR_CUR_A:      q_nxt.rdata = q_r.cur_a;
			ADDR_CUR_B:      q_nxt.rdata = q_r.cur_b;
			ADDR_OPEN_CFG:   q_nxt.rdata = q_r.open_cfg;
			ADDR_PROT_CFG:   q_nxt.rdata = q_r.fault_protection_config;
			ADDR_FAULT_STAT:
			begin
				q_nxt.rdata = 8'h00;
				q_nxt.rdata[STAT_THERMAL] = q_r.tsd_s2;
				q_nxt.rdata[STAT_OPEN_LSB +: N_OUT]  = open_seen;
				q_nxt.rdata[STAT_SHORT_LSB +: N_OUT] = short_seen;
			end
			default:         q_nxt.rdata = 8'h00;
		endcase

		// fault pin: OR of reported sources, released when none remains
		q_nxt.fault =
			(q_r.fault_protection_config[PROT_THERMAL_RPT] && q_r.tsd_s2)
			|| (q_r.fault_protection_config[PROT_SHORT_RPT] && |short_seen)
			|| (q_r.fault_protection_config[PROT_OPEN_RPT] && |open_seen);

		// brightness from the fixed gamma table
		q_nxt.level_a = GAMMA[ch_step[0]];
		q_nxt.level_b = GAMMA[ch_step[1]];
	end

	// state register; switch sync stages reset low, channels start off from their own reset
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			q_r                         <= '0;
			q_r.write_gate_key          <= RST_WRITE_GATE;
			q_r.mode_cfg                <= RST_MODE_CFG;
			q_r.low_scale               <= RST_LOW_SCALE;
			q_r.fade_on                 <= RST_FADE;
			q_r.fade_off                <= RST_FADE;
			q_r.cur_a                   <= RST_CUR;
			q_r.cur_b                   <= RST_CUR;
			q_r.open_cfg                <= RST_OPEN_CFG;
			q_r.fault_protection_config <= RST_PROT_CFG;
		end
		else
		begin
			q_r <= q_nxt;
		end
	end

	// open-drain fault pin: only ever pulls low
	assign FAULT_FLAG_N_OUT    = 1'b0;
	assign FAULT_FLAG_N_OE_OUT = q_r.fault;

	assign REG_RDATA_OUT                   = q_r.rdata;
	assign CHANNEL_ON_OUT                  = ch_on;
	assign HIGH_CURRENT_OUTPUT_A_LEVEL_OUT = q_r.level_a;
	assign HIGH_CURRENT_OUTPUT_B_LEVEL_OUT = q_r.level_b;
	// zero code means full scale, otherwise code/256 of maximum
	assign HIGH_CURRENT_OUTPUT_A_SCALE_OUT = q_r.cur_a;
	assign HIGH_CURRENT_OUTPUT_B_SCALE_OUT = q_r.cur_b;
	assign LOW_CHANNEL_CURRENT_SCALE_OUT   = q_r.low_scale[LOW_SCALE_LSB +: 3];
	assign SHORT_DETECT_ACTIVE_OUT = {N_OUT{q_r.fault_protection_config[PROT_SHORT_DET]}};
	assign OPEN_DETECT_ACTIVE_OUT  = q_r.fault_protection_config[PROT_OPEN_DET_LSB +: N_OUT];
endmodule
`default_nettype wire

// ### sfcp_top_assertions.sv
// concurrent checks on the ports of the switch fade control top
`timescale 1ns/100ps
`default_nettype none
module sfcp_top_checker
#(
	parameter int DEB_CYCLES = 20
)(
	input wire logic       CLK_IN,
	input wire logic       RST_N_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic       REG_WR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	input wire logic [1:0] HIGH_CHANNEL_SWITCH_INPUTS_IN,
	input wire logic       THERMAL_SHUTDOWN_IN,
	input wire logic [2:0] SHORT_SENSE_IN,
	input wire logic [2:0] OPEN_SENSE_IN,
	input wire logic       FAULT_FLAG_N_OE_OUT,
	input wire logic [1:0] CHANNEL_ON_OUT,
	input wire logic [9:0] HIGH_CURRENT_OUTPUT_A_LEVEL_OUT,
	input wire logic [2:0] SHORT_DETECT_ACTIVE_OUT
);
	logic [20:0] stab_a;
	logic        sw_a_q;
	wire logic   src_any = THERMAL_SHUTDOWN_IN | (|SHORT_SENSE_IN) | (|OPEN_SENSE_IN);
	wire logic [9:0] lvl = HIGH_CURRENT_OUTPUT_A_LEVEL_OUT;
	default clocking dc @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// cycles the raw pin of channel a has held still, saturating
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			sw_a_q <= 1'b0;
			stab_a <= '0;
		end
		else
		begin
			sw_a_q <= HIGH_CHANNEL_SWITCH_INPUTS_IN[0];
			if (HIGH_CHANNEL_SWITCH_INPUTS_IN[0] != sw_a_q)
				stab_a <= '0;
			else if (stab_a != '1)
				stab_a <= stab_a + 21'h1;
		end
	end
	property p_fault_cause;
		$rose(FAULT_FLAG_N_OE_OUT) |-> $past(src_any, 3);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault pin pulled without a source");
	property p_fault_release;
		!src_any |-> ##3 !FAULT_FLAG_N_OE_OUT;
	endproperty
	a_fault_release: assert property (p_fault_release) else $error("fault pin held after sources cleared");
	property p_debounce;
		$changed(CHANNEL_ON_OUT[0]) |-> stab_a >= DEB_CYCLES;
	endproperty
	a_debounce: assert property (p_debounce) else $error("channel toggled before switch settled");
	property p_reset_off;
		$rose(RST_N_IN) |-> CHANNEL_ON_OUT == 2'h0 && lvl == 10'h0;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("channel not off after reset");
	property p_short_all;
		SHORT_DETECT_ACTIVE_OUT == 3'h0 || SHORT_DETECT_ACTIVE_OUT == 3'h7;
	endproperty
	a_short_all: assert property (p_short_all) else $error("short detect not common to outputs");
	property p_ramp_up;
		CHANNEL_ON_OUT[0] && $past(CHANNEL_ON_OUT[0]) && $past(CHANNEL_ON_OUT[0], 2) |-> lvl >= $past(lvl);
	endproperty
	a_ramp_up: assert property (p_ramp_up) else $error("level fell while channel on");
	property p_ramp_down;
		!CHANNEL_ON_OUT[0] && !$past(CHANNEL_ON_OUT[0]) && !$past(CHANNEL_ON_OUT[0], 2) |-> lvl <= $past(lvl);
	endproperty
	a_ramp_down: assert property (p_ramp_down) else $error("level rose while channel off");
	property p_unmapped;
		(REG_ADDR_IN > 8'h0a || REG_ADDR_IN == 8'h00) |=> REG_RDATA_OUT == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped address read nonzero");
	property p_gate_write;
		(REG_WR_IN && REG_ADDR_IN == 8'h09) ##1 (REG_ADDR_IN == 8'h09) |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2);
	endproperty
	a_gate_write: assert property (p_gate_write) else $error("gate register write lost");
endmodule
bind sfcp_top sfcp_top_checker #(.DEB_CYCLES(DEB_CYCLES)) u_chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
	.REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN), .REG_WDATA_IN(REG_WDATA_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .HIGH_CHANNEL_SWITCH_INPUTS_IN(HIGH_CHANNEL_SWITCH_INPUTS_IN),
	.THERMAL_SHUTDOWN_IN(THERMAL_SHUTDOWN_IN), .SHORT_SENSE_IN(SHORT_SENSE_IN),
	.OPEN_SENSE_IN(OPEN_SENSE_IN), .FAULT_FLAG_N_OE_OUT(FAULT_FLAG_N_OE_OUT),
	.CHANNEL_ON_OUT(CHANNEL_ON_OUT), .HIGH_CURRENT_OUTPUT_A_LEVEL_OUT(HIGH_CURRENT_OUTPUT_A_LEVEL_OUT),
	.SHORT_DETECT_ACTIVE_OUT(SHORT_DETECT_ACTIVE_OUT));
`default_nettype wire

// ### sfcp_switch_model.sv
// chattering two-channel switch model driving the channel switch pins
`timescale 1ns/100ps
`default_nettype none
module sfcp_switch_model
(
	input  wire logic       clk_in,
	input  wire logic [1:0] level_in,
	input  wire logic [7:0] bounce_in,
	output logic      [1:0] pin_out
);
	logic [1:0] last_r = 2'h3;
	logic [7:0] cnt_r = 8'h00;
	// restart chatter on every new contact level
	always @(posedge clk_in)
	begin
		if (level_in != last_r)
			cnt_r <= bounce_in;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
		last_r <= level_in;
	end
	// chatter flips every cycle, so no stale level passes as settled
	assign pin_out = cnt_r[0] ? ~last_r : last_r;
endmodule
`default_nettype wire

// ### sfcp_top_test.sv
// self-checking bench for the switch fade control top
`timescale 1ns/100ps
`default_nettype none
module sfcp_top_test;
	import sfcp_pkg::*;
	localparam int DEB = 20;
	localparam logic [7:0] RV [0:11] = '{8'h00, RST_MODE_CFG, RST_LOW_SCALE, RST_FADE, RST_FADE,
		RST_CUR, RST_CUR, 8'h00, RST_OPEN_CFG, RST_WRITE_GATE, RST_PROT_CFG, 8'h00};
	logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, thermal = 1'b0, rd_req = 1'b0, rd_d = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, bounce = 8'h06, rdata, sc_a, sc_b, p, f, a, b;
	logic [2:0] short_s = 3'h0, open_s = 3'h0, low_sc, sdet, odet;
	logic [1:0] sw_lvl = 2'h3, sw_pin, on, on_seen = 2'h0, ev = 2'h0;
	logic       oe, flag_n;
	logic [9:0] lvl [2];
	logic [7:0] exp_rd [$];
	logic [1:0] exp_on [$];
	int         miscompares = 0, checks = 0, n;
	always #12.5 clk = ~clk;
	sfcp_switch_model u_sw (.clk_in(clk), .level_in(sw_lvl), .bounce_in(bounce), .pin_out(sw_pin));
	sfcp_top #(.DEB_CYCLES(DEB), .STEP_CYCLES(3)) dut (.CLK_IN(clk), .RST_N_IN(rst_n),
		.REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.HIGH_CHANNEL_SWITCH_INPUTS_IN(sw_pin), .FADE_ON_TIME_PIN_IN(8'h02),
		.FADE_OFF_TIME_PIN_IN(8'h02), .THERMAL_SHUTDOWN_IN(thermal), .SHORT_SENSE_IN(short_s),
		.OPEN_SENSE_IN(open_s), .FAULT_FLAG_N_OUT(flag_n), .FAULT_FLAG_N_OE_OUT(oe),
		.CHANNEL_ON_OUT(on), .HIGH_CURRENT_OUTPUT_A_LEVEL_OUT(lvl[0]),
		.HIGH_CURRENT_OUTPUT_B_LEVEL_OUT(lvl[1]), .HIGH_CURRENT_OUTPUT_A_SCALE_OUT(sc_a),
		.HIGH_CURRENT_OUTPUT_B_SCALE_OUT(sc_b), .LOW_CHANNEL_CURRENT_SCALE_OUT(low_sc),
		.SHORT_DETECT_ACTIVE_OUT(sdet), .OPEN_DETECT_ACTIVE_OUT(odet));
	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		checks++;
		if (seen !== expv)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask
	task print_verdict;
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic wrr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// open the gate for one write, then lock it again
	task automatic unl_wr(input logic [7:0] ad, input logic [7:0] d);
		wrr(ADDR_WRITE_GATE, UNLOCK_KEY);
		wrr(ad, d);
		wrr(ADDR_WRITE_GATE, 8'h00);
	endtask
	task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
		@(posedge clk);
		addr <= ad;
		rd_req <= 1'b1;
		exp_rd.push_back(e);
		@(posedge clk);
		rd_req <= 1'b0;
	endtask
	// flip one contact; expect a latch change or a quiet debounce span
	task automatic toggle(input int ch, input logic chg);
		logic [1:0] prev;
		prev = on;
		n = 0;
		if (chg)
		begin
			ev[ch] = ~ev[ch];
			exp_on.push_back(ev);
		end
		sw_lvl[ch] <= ~sw_lvl[ch];
		if (!chg)
			cyc(DEB + 10);
		while (chg && on === prev && n < 4 * DEB)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 4 * DEB)
			miscompares++;
		if (n >= 4 * DEB)
			print_verdict();
		@(posedge clk);
	endtask
	// wait for a level, checking every gamma step when a direction is given
	task automatic wait_lvl(input int ch, input logic [9:0] tgt, input int k, input int dir);
		logic [9:0] prev;
		int st;
		prev = lvl[ch];
		st = 0;
		n = 0;
		while (lvl[ch] !== tgt && n < 4000)
		begin
			@(negedge clk);
			n++;
			if (dir != 0 && lvl[ch] !== prev)
			begin
				k += dir;
				st++;
				check(16'(lvl[ch]), 16'(GAMMA[k]));
			end
			prev = lvl[ch];
		end
		if (dir != 0)
			check(16'(st), 16'd62);
		if (n >= 4000)
			miscompares++;
		if (n >= 4000)
			print_verdict();
		@(posedge clk);
	endtask
	// result watchers: read data one cycle after its address, latch changes as they occur
	always @(posedge clk) rd_d <= rd_req;
	always @(negedge clk)
	begin
		if (rd_d)
			check(16'(rdata), 16'(exp_rd.pop_front()));
		if (on !== on_seen)
		begin
			check(16'(on), 16'(exp_on.size() != 0 ? exp_on.pop_front() : ~on));
			on_seen = on;
		end
	end
	initial
	begin
		void'($urandom(32'h1f37531e));
		cyc(16);
		rst_n <= 1'b1;
		cyc(DEB + 8);
		check(16'({on, lvl[0], lvl[1]}), 16'h0);
		for (int i = 0; i < 12; i++)
			rdc(i[7:0], RV[i]);
		wrr(ADDR_PROT_CFG, 8'h00);
		rdc(ADDR_PROT_CFG, RST_PROT_CFG);
		a = 8'($urandom);
		b = 8'($urandom);
		f = 8'($urandom);
		unl_wr(ADDR_CUR_A, a);
		unl_wr(ADDR_CUR_B, b);
		unl_wr(ADDR_LOW_SCALE, f);
		cyc(2);
		check({sc_a, sc_b}, {a, b});
		check(16'(low_sc), 16'(f[2:0]));
		wrr(ADDR_WRITE_GATE, UNLOCK_KEY);
		repeat (40)
		begin
			p = 8'($urandom);
			f = 8'($urandom);
			wrr(ADDR_PROT_CFG, p);
			thermal <= f[6];
			short_s <= f[2:0];
			open_s <= f[5:3];
			cyc(5);
			check(16'(oe), 16'((p[6] & f[6]) | (p[5] & |(f[2:0] & {3{p[4]}})) | (p[3] & |(f[5:3] & p[2:0]))));
			check(16'({flag_n, sdet, odet}), 16'({1'b0, {3{p[4]}}, p[2:0]}));
			rdc(ADDR_FAULT_STAT, {1'b0, f[6], f[5:3] & p[2:0], f[2:0] & {3{p[4]}}});
		end
		rdc(ADDR_PROT_CFG, p & 8'h7f);
		thermal <= 1'b0;
		short_s <= 3'h0;
		open_s <= 3'h0;
		wrr(ADDR_MODE_CFG, 8'h07);
		wrr(ADDR_FADE_ON, 8'h02);
		wrr(ADDR_FADE_OFF, 8'h02);
		wrr(ADDR_WRITE_GATE, 8'h00);
		toggle(0, 1);
		wait_lvl(0, 10'd1000, 0, 1);
		check(16'(n >= 370 && n <= 378), 16'h1);
		toggle(0, 0);
		toggle(0, 1);
		wait_lvl(0, 10'd0, 62, -1);
		check(16'(n >= 370 && n <= 378), 16'h1);
		toggle(0, 0);
		toggle(0, 1);
		cyc(100);
		toggle(0, 0);
		toggle(0, 1);
		check(16'(lvl[0] > 10'd0 && lvl[0] < 10'd1000), 16'h1);
		wait_lvl(0, 10'd0, 0, 0);
		check(16'(n < 360), 16'h1);
		toggle(0, 0);
		sw_lvl[0] <= 1'b0;
		cyc(DEB / 2);
		sw_lvl[0] <= 1'b1;
		cyc(DEB + 10);
		unl_wr(ADDR_FADE_ON, 8'h00);
		toggle(0, 1);
		wait_lvl(0, 10'd1000, 0, 0);
		check(16'(n >= 2995 && n <= 3010), 16'h1);
		toggle(0, 0);
		// level mode; fade-on from the pin code so channel b still walks every step
		unl_wr(ADDR_MODE_CFG, 8'h04);
		toggle(1, 0);
		toggle(1, 1);
		wait_lvl(1, 10'd1000, 0, 1);
		toggle(1, 1);
		wait_lvl(1, 10'd0, 62, -1);
		print_verdict();
	end
endmodule
`default_nettype wire
